/* src/fom_pkg.sv */
// fom_pkg: constants and types shared by the fieldbus object mapper.
// assumes one clock domain; object numbers are internal register numbers.
package fom_pkg;
    // ------------------------------------------------------------
    // object addressing
    // ------------------------------------------------------------
    localparam logic [15:0] FOM_OBJ_BASE = 16'h2001; // user index of register zero
    localparam logic [15:0] FOM_REG_NOM_VOLT = 16'h0079; // nominal voltage, single_precision_real
    localparam logic [15:0] FOM_REG_REMOTE = 16'h0192; // remote control request
    localparam logic [15:0] FOM_REG_SET_VOLT = 16'h01f4; // voltage set value
    localparam logic [15:0] FOM_REG_SET_CURR = 16'h01f5; // current set value
    localparam logic [15:0] FOM_REG_SET_POW = 16'h01f6; // power set value
    localparam logic [15:0] FOM_REG_STATUS = 16'h01f9; // unit status word
    localparam logic [15:0] FOM_REG_ACT_VOLT = 16'h01fb; // actual voltage
    localparam logic [15:0] FOM_REG_ACT_CURR = 16'h01fc; // actual current
    localparam logic [15:0] FOM_REG_ACT_POW = 16'h01fd; // actual power
    // ------------------------------------------------------------
    // values and fields
    // ------------------------------------------------------------
    localparam logic [15:0] FOM_FULL_SCALE = 16'hcccc; // code for 100 percent
    localparam logic [15:0] FOM_REMOTE_ON = 16'hff00; // request remote control
    localparam logic [15:0] FOM_REMOTE_OFF = 16'h0000; // back to manual control
    localparam logic [15:0] FOM_SET_RESET = 16'h0000; // set values after reset
    localparam logic [14:0] FOM_DAC_STEPS = 15'h6666; // effective steps, 26214
    localparam int FOM_BIT_MASTER = 6; // status: configured as master
    localparam int FOM_BIT_DC_ON = 7; // status: dc terminal on
    localparam int FOM_BIT_CC = 10; // status: constant_current_regulation
    localparam int FOM_USED_SLOTS = 4; // cyclic slots that carry values
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FOM_OK = 3'h0, // access done
        FOM_NO_OBJECT = 3'h1, // index not reachable
        FOM_READ_ONLY = 3'h2, // write to a read-only object
        FOM_RANGE = 3'h3, // value out of range
        FOM_DENIED = 3'h4 // refused in present unit state
    } fom_err_t;
    typedef enum logic {
        FOM_LOCAL = 1'b0, // manual control
        FOM_REMOTE = 1'b1 // remote control active
    } fom_ctl_t;
    typedef struct packed {
        logic write; // 1 write, 0 read
        logic [15:0] index; // user object index
        logic [31:0] data; // write data, 16-bit objects use low half
    } fom_req_t;
    typedef struct packed {
        fom_err_t err; // outcome
        logic [31:0] data; // read data, zero on error or write
    } fom_rsp_t;
    typedef struct packed {
        logic [31:0] status; // unit status word
        logic [15:0] volt; // actual voltage code
        logic [15:0] curr; // actual current code
        logic [15:0] pow; // actual power code
        logic [31:0] nom_volt; // nominal voltage, single_precision_real
    } fom_meas_t;
endpackage : fom_pkg

/* src/fom_mapper.sv */
// fom_mapper: object access port and cyclic slots of a programmable supply.
// assumes request, measurement and permit inputs come from logic on sys_clk_in.
// Function
// - eight cyclic slots, only first four filled
// - slot one carries unit status word
// - status bits 6,7,10 mean master, on, cc
// - slots two to four carry actual values
// - values are percent codes, 0xcccc full scale
// - effective resolution is 26214 steps
// - object index minus 0x2001 gives register
// - nominal voltage object is single precision real
// - 0xff00 enters remote, 0x0000 leaves it
// - set values accepted only under remote control
// - accesses carry only data, no checksum
// - only listed registers reachable over link
// - remote request may be denied; starts local
// - reads allowed at any time
`timescale 1ns/100ps
module fom_mapper #(
    parameter int SLOTS = 8 // cyclic slot count
) (
    input wire logic sys_clk_in, // 25 MHz clock
    input wire logic rst_b_in, // synchronous reset, active low
    input wire logic req_valid_in, // request present this cycle
    input wire fom_pkg::fom_req_t req_in, // request fields
    input wire fom_pkg::fom_meas_t meas_in, // measured values of the unit
    input wire logic remote_allow_in, // unit settings permit remote control
    output logic rsp_valid_out, // one-cycle answer strobe
    output fom_pkg::fom_rsp_t rsp_out, // answer fields
    output logic [SLOTS-1:0][31:0] slots_out, // cyclic input data
    output logic remote_out, // remote control active
    output logic master_out, // unit configured as master
    output logic dc_on_out, // dc terminal on
    output logic cc_mode_out, // constant_current_regulation
    output logic [14:0] dac_volt_out, // voltage setting, effective steps
    output logic [14:0] dac_curr_out, // current setting, effective steps
    output logic [14:0] dac_pow_out // power setting, effective steps
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (SLOTS < fom_pkg::FOM_USED_SLOTS)
    begin : g_bad_slots
        $error("SLOTS must hold the four used slots");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fom_pkg::fom_ctl_t ctl_reg, ctl_next; // control location
    logic [15:0] set_volt_reg, set_volt_next; // voltage set code
    logic [15:0] set_curr_reg, set_curr_next; // current set code
    logic [15:0] set_pow_reg, set_pow_next; // power set code
    logic rsp_valid_reg, rsp_valid_next; // answer strobe
    fom_pkg::fom_rsp_t rsp_reg, rsp_next; // answer fields
    logic [SLOTS-1:0][31:0] slots_reg, slots_next; // cyclic image
    logic [2:0] flags_reg, flags_next; // master, on, cc
    logic [15:0] reg_num; // register number of request
    logic [15:0] wr16; // low half of write data
    logic is_set; // request hits a set value object
    logic in_range; // write code within full scale

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // index to register number, plain subtraction
    assign reg_num = req_in.index - fom_pkg::FOM_OBJ_BASE;
    assign wr16 = req_in.data[15:0];
    assign is_set = (reg_num == fom_pkg::FOM_REG_SET_VOLT)
        || (reg_num == fom_pkg::FOM_REG_SET_CURR)
        || (reg_num == fom_pkg::FOM_REG_SET_POW);
    assign in_range = wr16 <= fom_pkg::FOM_FULL_SCALE;

    // ------------------------------------------------------------
    // object access, next values
    // ------------------------------------------------------------
    // one answer per request, frame is bare data with no check field
    always_comb
    begin
        ctl_next = ctl_reg;
        set_volt_next = set_volt_reg;
        set_curr_next = set_curr_reg;
        set_pow_next = set_pow_reg;
        rsp_valid_next = req_valid_in;
        rsp_next = '{err: fom_pkg::FOM_OK, data: 32'h0000_0000};
        if (req_valid_in)
        begin
            // an index below the base wraps high and misses every object
            if (req_in.index < fom_pkg::FOM_OBJ_BASE)
            begin
                rsp_next.err = fom_pkg::FOM_NO_OBJECT;
            end
            else if (!req_in.write)
            begin
                // reads ignore the control location
                unique case (reg_num)
                    fom_pkg::FOM_REG_NOM_VOLT: rsp_next.data = meas_in.nom_volt;
                    fom_pkg::FOM_REG_REMOTE: rsp_next.data = (ctl_reg == fom_pkg::FOM_REMOTE)
                        ? {16'h0000, fom_pkg::FOM_REMOTE_ON} : 32'h0000_0000;
                    fom_pkg::FOM_REG_SET_VOLT: rsp_next.data = {16'h0000, set_volt_reg};
                    fom_pkg::FOM_REG_SET_CURR: rsp_next.data = {16'h0000, set_curr_reg};
                    fom_pkg::FOM_REG_SET_POW: rsp_next.data = {16'h0000, set_pow_reg};
                    fom_pkg::FOM_REG_STATUS: rsp_next.data = meas_in.status;
                    fom_pkg::FOM_REG_ACT_VOLT: rsp_next.data = {16'h0000, meas_in.volt};
                    fom_pkg::FOM_REG_ACT_CURR: rsp_next.data = {16'h0000, meas_in.curr};
                    fom_pkg::FOM_REG_ACT_POW: rsp_next.data = {16'h0000, meas_in.pow};
                    default: rsp_next.err = fom_pkg::FOM_NO_OBJECT;
                endcase
            end
            else if (reg_num == fom_pkg::FOM_REG_REMOTE)
            begin
                // remote entry needs the unit's permit, exit always works
                if (wr16 == fom_pkg::FOM_REMOTE_OFF)
                begin
                    ctl_next = fom_pkg::FOM_LOCAL;
                end
                else if (wr16 != fom_pkg::FOM_REMOTE_ON)
                begin
                    rsp_next.err = fom_pkg::FOM_RANGE;
                end
                else if (remote_allow_in)
                begin
                    ctl_next = fom_pkg::FOM_REMOTE;
                end
                else
                begin
                    rsp_next.err = fom_pkg::FOM_DENIED;
                end
            end
            else if (is_set)
            begin
                // set values only under remote control and within scale
                if (ctl_reg != fom_pkg::FOM_REMOTE)
                begin
                    rsp_next.err = fom_pkg::FOM_DENIED;
                end
                else if (!in_range)
                begin
                    rsp_next.err = fom_pkg::FOM_RANGE;
                end
                else if (reg_num == fom_pkg::FOM_REG_SET_VOLT)
                begin
                    set_volt_next = wr16;
                end
                else if (reg_num == fom_pkg::FOM_REG_SET_CURR)
                begin
                    set_curr_next = wr16;
                end
                else
                begin
                    set_pow_next = wr16;
                end
            end
            else if ((reg_num == fom_pkg::FOM_REG_NOM_VOLT)
                || (reg_num == fom_pkg::FOM_REG_STATUS)
                || (reg_num == fom_pkg::FOM_REG_ACT_VOLT)
                || (reg_num == fom_pkg::FOM_REG_ACT_CURR)
                || (reg_num == fom_pkg::FOM_REG_ACT_POW))
            begin
                rsp_next.err = fom_pkg::FOM_READ_ONLY;
            end
            else
            begin
                rsp_next.err = fom_pkg::FOM_NO_OBJECT;
            end
        end
    end

    // ------------------------------------------------------------
    // cyclic slots and status flags, next values
    // ------------------------------------------------------------
    // unused slots stay zero
    always_comb
    begin
        slots_next = '0;
        slots_next[0] = meas_in.status;
        slots_next[1] = {16'h0000, meas_in.volt};
        slots_next[2] = {16'h0000, meas_in.curr};
        slots_next[3] = {16'h0000, meas_in.pow};
        flags_next = {meas_in.status[fom_pkg::FOM_BIT_CC],
            meas_in.status[fom_pkg::FOM_BIT_DC_ON],
            meas_in.status[fom_pkg::FOM_BIT_MASTER]};
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset leaves the unit under manual control
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_b_in)
        begin
            ctl_reg <= fom_pkg::FOM_LOCAL;
            set_volt_reg <= fom_pkg::FOM_SET_RESET;
            set_curr_reg <= fom_pkg::FOM_SET_RESET;
            set_pow_reg <= fom_pkg::FOM_SET_RESET;
            rsp_valid_reg <= 1'b0;
            rsp_reg <= '0;
            slots_reg <= '0;
            flags_reg <= 3'h0;
        end
        else
        begin
            ctl_reg <= ctl_next;
            set_volt_reg <= set_volt_next;
            set_curr_reg <= set_curr_next;
            set_pow_reg <= set_pow_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_reg <= rsp_next;
            slots_reg <= slots_next;
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // dropping the lsb maps 52428 codes onto 26214 steps
    assign dac_volt_out = set_volt_reg[15:1];
    assign dac_curr_out = set_curr_reg[15:1];
    assign dac_pow_out = set_pow_reg[15:1];
    assign remote_out = ctl_reg;
    assign rsp_valid_out = rsp_valid_reg;
    assign rsp_out = rsp_reg;
    assign slots_out = slots_reg;
    assign {cc_mode_out, dc_on_out, master_out} = flags_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    logic rd_req; // read request this cycle
    logic set_wr; // set value write this cycle
    assign rd_req = req_valid_in && !req_in.write;
    assign set_wr = req_valid_in && req_in.write && is_set;

    chk_slots_empty: assert property (##1 slots_out[SLOTS-1:fom_pkg::FOM_USED_SLOTS] == '0)
        else $error("unused slot not empty");
    chk_slot_status: assert property (##1 slots_out[0] == $past(meas_in.status))
        else $error("slot one lost status");
    chk_status_flags: assert property (##1 {cc_mode_out, master_out}
        == {$past(meas_in.status[10]), $past(meas_in.status[6])})
        else $error("status flags wrong");
    chk_slot_actual: assert property (##1 slots_out[2][15:0] == $past(meas_in.curr))
        else $error("slot three not current");
    chk_dac_steps: assert property (dac_curr_out <= fom_pkg::FOM_DAC_STEPS)
        else $error("dac beyond effective steps");
    chk_index_map: assert property (rd_req && req_in.index == 16'h21fa
        |=> rsp_out.err == fom_pkg::FOM_OK && rsp_out.data == $past(meas_in.status))
        else $error("index map wrong");
    chk_nominal_real: assert property (rd_req && req_in.index == 16'h207a
        |=> rsp_out.data == $past(meas_in.nom_volt))
        else $error("nominal not delivered");
    chk_remote_enter: assert property (req_valid_in && req_in.write
        && req_in.index == 16'h2193 && req_in.data[15:0] == 16'hff00 && remote_allow_in
        |=> remote_out)
        else $error("remote not entered");
    chk_remote_gate: assert property (set_wr && !remote_out
        |=> rsp_out.err == fom_pkg::FOM_DENIED && $stable(dac_volt_out))
        else $error("set accepted in local");
    chk_remote_deny: assert property (req_valid_in && req_in.write
        && reg_num == fom_pkg::FOM_REG_REMOTE && !remote_allow_in && !remote_out
        |=> !remote_out && rsp_out.err == fom_pkg::FOM_DENIED)
        else $error("remote not denied");
    chk_read_free: assert property (rd_req && reg_num == fom_pkg::FOM_REG_ACT_POW
        |=> rsp_valid_out && rsp_out.err == fom_pkg::FOM_OK)
        else $error("read refused");
    chk_unmapped: assert property (req_valid_in && req_in.index == 16'h2000
        |=> rsp_out.err == fom_pkg::FOM_NO_OBJECT)
        else $error("unmapped object answered");
    chk_range_keep: assert property (set_wr && remote_out && !in_range
        |=> rsp_out.err == fom_pkg::FOM_RANGE && $stable(set_volt_reg))
        else $error("out of range set taken");

    cov_remote_on: cover property (!remote_out ##1 remote_out);
    cov_set_taken: cover property (set_wr && remote_out && in_range);
    cov_denied: cover property (rsp_valid_out && rsp_out.err == fom_pkg::FOM_DENIED);
    cov_back_to_back: cover property (rsp_valid_out [*3]);

endmodule : fom_mapper

/* verif/fom_master_model.sv */
// fom_master_model: fieldbus master that issues single object accesses.
// assumes the mapper takes a request on a rising edge and answers one cycle later.
`timescale 1ns/100ps
module fom_master_model (
    input wire logic sys_clk_in, // bus clock
    output logic req_valid_out, // request strobe
    output fom_pkg::fom_req_t req_out, // request fields
    input wire logic rsp_valid_in, // answer strobe
    input wire fom_pkg::fom_rsp_t rsp_in // answer fields
);
    logic remote_ok = 1'b0; // remote entry was answered ok
    logic early_set = 1'b0; // bench orders a set value while local
    // ----------------------------------------------------------------
    // idle state
    // ----------------------------------------------------------------
    initial
    begin
        req_valid_out = 1'b0;
        req_out = '0;
    end
    // ----------------------------------------------------------------
    // one access, driven on the falling edge, answer taken one cycle on
    // ----------------------------------------------------------------
    task access(input logic wr, input logic [15:0] idx, input logic [31:0] dat,
                output logic [34:0] rsp, output logic seen);
        logic is_set;
        is_set = wr && (idx >= 16'h21f5) && (idx <= 16'h21f7);
        seen = 1'b0;
        rsp = '0;
        // set values go out only once remote control is held, or while early_set is raised
        if (!is_set || remote_ok || early_set)
        begin
            @(negedge sys_clk_in);
            req_valid_out = 1'b1;
            req_out.write = wr;
            req_out.index = idx;
            req_out.data = dat;
            @(negedge sys_clk_in);
            seen = rsp_valid_in;
            rsp = rsp_in;
            req_valid_out = 1'b0;
            // released fields must not keep looking valid
            req_out = fom_pkg::fom_req_t'(~req_out);
            if (wr && idx == 16'h2193 && seen && rsp_in.err == fom_pkg::FOM_OK)
                remote_ok = (dat[15:0] == 16'hff00);
        end
    endtask : access
endmodule : fom_master_model

/* verif/tb_top.sv */
// tb_top: self-checking bench for the fieldbus object mapper.
// assumes fom_pkg and fom_mapper are compiled first; one 25 MHz clock.
`timescale 1ns/100ps
module tb_top;
    logic sys_clk_in; // 25 MHz clock
    logic rst_b_in; // synchronous reset, active low
    logic req_valid_in; // from master model
    fom_pkg::fom_req_t req_in; // from master model
    fom_pkg::fom_meas_t meas_in; // measured values
    logic remote_allow_in; // unit permits remote
    logic rsp_valid_out; // answer strobe
    fom_pkg::fom_rsp_t rsp_out; // answer fields
    logic [7:0][31:0] slots_out; // cyclic slots
    logic remote_out; // remote active
    logic master_out; // status flag
    logic dc_on_out; // status flag
    logic cc_mode_out; // status flag
    logic [14:0] dac_volt_out; // voltage setting
    logic [14:0] dac_curr_out; // current setting
    logic [14:0] dac_pow_out; // power setting
    int errors = 0; // mismatches
    int n_checks = 0; // comparisons
    // ----------------------------------------------------------------
    // clock, instances
    // ----------------------------------------------------------------
    initial
    begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    fom_mapper #(.SLOTS(8)) dut_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .meas_in(meas_in),
        .remote_allow_in(remote_allow_in), .rsp_valid_out(rsp_valid_out),
        .rsp_out(rsp_out), .slots_out(slots_out), .remote_out(remote_out),
        .master_out(master_out), .dc_on_out(dc_on_out), .cc_mode_out(cc_mode_out),
        .dac_volt_out(dac_volt_out), .dac_curr_out(dac_curr_out),
        .dac_pow_out(dac_pow_out));
    fom_master_model master_u (.sys_clk_in(sys_clk_in), .req_valid_out(req_valid_in),
        .req_out(req_in), .rsp_valid_in(rsp_valid_out), .rsp_in(rsp_out));
    // ----------------------------------------------------------------
    // compare and access helpers
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one access through the master, answer strobe, code and data judged
    task acc(input logic wr, input logic [15:0] idx, input logic [31:0] dat,
             input logic [2:0] e_err, input logic [31:0] e_dat);
        logic [34:0] rsp;
        logic seen;
        master_u.access(wr, idx, dat, rsp, seen);
        chk({31'h0, seen}, 32'h1);
        chk({29'h0, rsp[34:32]}, {29'h0, e_err});
        chk(rsp[31:0], e_dat);
    endtask : acc
    task tally_and_finish;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset_state;
        chk({31'h0, remote_out}, 32'h0);
        acc(1'b0, 16'h2193, 32'h0, 3'h0, 32'h0);
    endtask : t_reset_state
    task t_slots;
        @(negedge sys_clk_in);
        meas_in.status = 32'h000004c0;
        meas_in.volt = 16'h263a;
        meas_in.curr = 16'h0c9b;
        meas_in.pow = 16'h0925;
        meas_in.nom_volt = 32'h437a0000;
        @(negedge sys_clk_in);
        chk(slots_out[0], 32'h000004c0);
        chk(slots_out[1], 32'h0000263a);
        chk(slots_out[2], 32'h00000c9b);
        chk(slots_out[3], 32'h00000925);
        for (int k = 4; k < 8; k++)
            chk(slots_out[k], 32'h0);
        chk({29'h0, master_out, dc_on_out, cc_mode_out}, 32'h7);
        meas_in.status = 32'h00000440; // terminal switched off
        @(negedge sys_clk_in);
        chk({29'h0, master_out, dc_on_out, cc_mode_out}, 32'h5);
    endtask : t_slots
    // reads while local, plus unreachable and read-only objects
    task t_reads;
        acc(1'b0, 16'h21fa, 32'h0, 3'h0, 32'h440);
        acc(1'b0, 16'h21fc, 32'h0, 3'h0, 32'h263a);
        acc(1'b0, 16'h21fd, 32'h0, 3'h0, 32'hc9b);
        acc(1'b0, 16'h21fe, 32'h0, 3'h0, 32'h925);
        acc(1'b0, 16'h207a, 32'h0, 3'h0, 32'h437a0000);
        acc(1'b0, 16'h2000, 32'h0, 3'h1, 32'h0);
        acc(1'b0, 16'h2001, 32'h0, 3'h1, 32'h0);
        acc(1'b1, 16'h207a, 32'h1, 3'h2, 32'h0);
        acc(1'b1, 16'h21fc, 32'h1, 3'h2, 32'h0);
    endtask : t_reads
    task t_remote;
        master_u.early_set = 1'b1;
        acc(1'b1, 16'h21f5, 32'h1000, 3'h4, 32'h0);
        master_u.early_set = 1'b0;
        remote_allow_in = 1'b0;
        acc(1'b1, 16'h2193, 32'hff00, 3'h4, 32'h0);
        chk({31'h0, remote_out}, 32'h0);
        remote_allow_in = 1'b1;
        acc(1'b1, 16'h2193, 32'h1234, 3'h3, 32'h0);
        acc(1'b1, 16'h2193, 32'hff00, 3'h0, 32'h0);
        chk({31'h0, remote_out}, 32'h1);
        acc(1'b0, 16'h2193, 32'h0, 3'h0, 32'hff00);
    endtask : t_remote
    // set values under remote, range edge, then exit and refusal
    task t_setvals;
        acc(1'b1, 16'h21f5, 32'hcccc, 3'h0, 32'h0);
        chk({17'h0, dac_volt_out}, 32'h6666);
        acc(1'b1, 16'h21f5, 32'h0000, 3'h0, 32'h0);
        chk({17'h0, dac_volt_out}, 32'h0);
        acc(1'b1, 16'h21f6, 32'h0c0c, 3'h0, 32'h0);
        chk({17'h0, dac_curr_out}, 32'h0606);
        acc(1'b1, 16'h21f6, 32'hcccd, 3'h3, 32'h0);
        chk({17'h0, dac_curr_out}, 32'h0606);
        acc(1'b0, 16'h21f6, 32'h0, 3'h0, 32'h0c0c);
        acc(1'b1, 16'h21f7, 32'h0003, 3'h0, 32'h0);
        acc(1'b1, 16'h21f7, 32'h0002, 3'h0, 32'h0);
        chk({17'h0, dac_pow_out}, 32'h1);
        acc(1'b1, 16'h2193, 32'h0000, 3'h0, 32'h0);
        chk({31'h0, remote_out}, 32'h0);
        master_u.early_set = 1'b1;
        acc(1'b1, 16'h21f7, 32'h0008, 3'h4, 32'h0);
        chk({17'h0, dac_pow_out}, 32'h1);
    endtask : t_setvals
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        rst_b_in = 1'b0;
        meas_in = '0;
        remote_allow_in = 1'b1;
        repeat (20) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        t_reset_state;
        t_slots;
        t_reads;
        t_remote;
        t_setvals;
        tally_and_finish;
    end
    initial
    begin
        #(2000 * 40);
        errors++;
        tally_and_finish;
    end
endmodule : tb_top
